// File: hw/fault_ctl_bank.sv
// Fault status, monitor select, bias, GPIO and switch control register bank
module fault_ctl_bank
    import fault_ctl_pkg::*;
#(
    parameter int PINS = GPIO_PINS
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Conversion engine status
    input  wire logic              startup_done,
    input  wire logic              conv_start,
    input  wire logic              data_ready_n,
    input  wire logic              power_down_command,
    input  wire logic              data_read_start,
    input  wire logic              amp_bypass,
    // Monitor comparators
    input  wire monitor_raw_s      monitor_raw,
    // Shared GPIO pins
    input  wire logic [PINS-1:0]   gpio_in,
    output logic      [PINS-1:0]   gpio_out,
    output logic      [PINS-1:0]   gpio_oe,
    output logic      [PINS-1:0]   pin_function_select,
    // Analog controls and status prefix
    output analog_ctl_s            analog_ctl,
    output logic                   status_append_enable,
    output logic                   prefix_valid,
    output logic [7:0]             prefix_byte
);

    initial begin
        if (PINS != GPIO_PINS) $error("fault_ctl_bank serves exactly four pins");
    end

    // Register state
    logic [7:0]      sysctl, next_sysctl;
    logic [7:0]      bias, next_bias;
    logic [7:0]      excite, next_excite;
    logic [7:0]      refctl, next_refctl;
    logic [PINS-1:0] gpio_cfg, next_gpio_cfg;
    logic [PINS-1:0] gpio_dir, next_gpio_dir;
    logic [PINS-1:0] gpio_dat, next_gpio_dat;
    logic            por_flag, next_por_flag;
    logic            ready_n, next_ready_n;
    logic            data_ready_n_d, next_data_ready_n_d;
    // Bus handshake and status prefix state
    logic            aw_held, next_aw_held;
    logic            w_held, next_w_held;
    logic [7:0]      aw_addr, next_aw_addr;
    logic [31:0]     w_data, next_w_data;
    logic [3:0]      w_strb, next_w_strb;
    logic            bvalid, next_bvalid;
    logic [1:0]      bresp, next_bresp;
    logic            rvalid, next_rvalid;
    logic [31:0]     rdata, next_rdata;
    logic [1:0]      rresp, next_rresp;
    logic [7:0]      prefix, next_prefix;
    logic            pvalid, next_pvalid;

    logic [5:0]      flags;
    logic [5:0]      fault_en;
    logic            conv_end;
    logic            do_write;
    logic [7:0]      status_byte;
    logic [2:0]      mon_sel;

    assign mon_sel = sysctl[2:0];
    // Conversion completes on the falling edge of the active-low ready
    assign conv_end = data_ready_n_d & ~data_ready_n;

    // Rail bits from excitation enable, reference bits from two-bit field
    assign fault_en = {{4{excite[EX_RAIL]}}, refctl[1], refctl[0]};

    // Monitor levels latched per conversion, published at its end
    fault_latch #(
        .WIDTH(6)
    ) u_fault_latch (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .conv_start  (conv_start),
        .conv_end    (conv_end),
        .fault_in    (monitor_raw),
        .fault_enable(fault_en),
        .flags       (flags)
    );

    // Status byte assembly
    assign status_byte = {por_flag, ready_n, flags};

    // Write taken once both address and data are held
    assign do_write = aw_held & w_held & ~bvalid;

    // Next-state logic for bus and registers
    always_comb begin
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_rvalid   = rvalid;
        next_rdata    = rdata;
        next_rresp    = rresp;
        next_sysctl   = sysctl;
        next_bias     = bias;
        next_excite   = excite;
        next_refctl   = refctl;
        next_gpio_cfg = gpio_cfg;
        next_gpio_dir = gpio_dir;
        next_gpio_dat = gpio_dat;
        next_por_flag = por_flag;
        next_ready_n  = ~startup_done;
        next_data_ready_n_d   = data_ready_n;
        next_prefix   = prefix;
        next_pvalid   = 1'b0;

        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end

        // Input pins reflect level, output pins keep written value
        for (int i = 0; i < PINS; i++) begin
            if (!gpio_dir[i]) begin
                next_gpio_dat[i] = gpio_in[i];
            end
        end

        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            if (w_strb[0]) begin
                unique case (aw_addr)
                    ADDR_STATUS: begin
                        // Only a zero write clears power-on flag
                        if (!w_data[ST_POR]) next_por_flag = 1'b0;
                    end
                    ADDR_SYSCTL:    next_sysctl = w_data[7:0];
                    ADDR_BIAS:      next_bias = w_data[7:0];
                    ADDR_EXCITE:    next_excite = w_data[7:0];
                    ADDR_REFCTL:    next_refctl = w_data[7:0];
                    ADDR_GPIO_CFG:  next_gpio_cfg = w_data[PINS-1:0];
                    ADDR_GPIO_DATA: begin
                        next_gpio_dir = w_data[2*PINS-1:PINS];
                        for (int i = 0; i < PINS; i++) begin
                            if (w_data[PINS+i]) next_gpio_dat[i] = w_data[i];
                        end
                    end
                    ADDR_EFFECT: begin
                        if (w_data[EF_POWER_DOWN]) next_excite[EX_SWITCH] = 1'b0;
                    end
                    default:        next_bresp = RESP_SLVERR;
                endcase
            end
            if (!(aw_addr inside {ADDR_STATUS, ADDR_SYSCTL, ADDR_BIAS, ADDR_EXCITE,
                                  ADDR_REFCTL, ADDR_GPIO_CFG, ADDR_GPIO_DATA,
                                  ADDR_EFFECT})) begin
                next_bresp = RESP_SLVERR;
            end
        end

        // Pin power-down command opens the switch
        if (power_down_command) begin
            next_excite[EX_SWITCH] = 1'b0;
        end

        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // Reads have no side effect on any flag
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = '0;
            unique case (s_axi_araddr)
                ADDR_STATUS:    next_rdata[7:0] = status_byte;
                ADDR_SYSCTL:    next_rdata[7:0] = sysctl;
                ADDR_BIAS:      next_rdata[7:0] = bias;
                ADDR_EXCITE:    next_rdata[7:0] = excite;
                ADDR_REFCTL:    next_rdata[7:0] = refctl;
                ADDR_GPIO_CFG:  next_rdata[PINS-1:0] = gpio_cfg;
                ADDR_GPIO_DATA: next_rdata[2*PINS-1:0] = {gpio_dir, gpio_dat};
                ADDR_EFFECT:    next_rdata = '0;
                default:        next_rresp = RESP_SLVERR;
            endcase
        end

        // Status prefix for a conversion data read
        if (data_read_start && sysctl[SC_APPEND]) begin
            next_prefix = status_byte;
            next_pvalid = 1'b1;
        end
    end

    // Register all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= '0;
            w_data   <= '0;
            w_strb   <= '0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
            rvalid   <= 1'b0;
            rdata    <= '0;
            rresp    <= RESP_OKAY;
            sysctl   <= '0;
            bias     <= '0;
            excite   <= '0;
            refctl   <= '0;
            gpio_cfg <= '0;
            gpio_dir <= '0;
            gpio_dat <= '0;
            por_flag <= STATUS_RESET[ST_POR];
            ready_n  <= STATUS_RESET[ST_RDY_N];
            data_ready_n_d   <= 1'b1;
            prefix   <= '0;
            pvalid   <= 1'b0;
        end else begin
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
            sysctl   <= next_sysctl;
            bias     <= next_bias;
            excite   <= next_excite;
            refctl   <= next_refctl;
            gpio_cfg <= next_gpio_cfg;
            gpio_dir <= next_gpio_dir;
            gpio_dat <= next_gpio_dat;
            por_flag <= next_por_flag;
            ready_n  <= next_ready_n;
            data_ready_n_d   <= next_data_ready_n_d;
            prefix   <= next_prefix;
            pvalid   <= next_pvalid;
        end
    end

    // Bus handshake outputs
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_arready = ~rvalid;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

    // GPIO pins
    assign pin_function_select = gpio_cfg;
    assign gpio_out = gpio_dat;
    assign gpio_oe  = gpio_cfg & gpio_dir;

    // Analog control decode
    always_comb begin
        analog_ctl                       = '0;
        analog_ctl.bias_level_twelfth    = bias[BIAS_LEVEL];
        analog_ctl.bias_pin_enable       = bias[BIAS_PINS-1:0];
        analog_ctl.inputs_disconnect     = (mon_sel == MON_AVDD) || (mon_sel == MON_IOVDD);
        analog_ctl.gain_force_unity      = analog_ctl.inputs_disconnect;
        unique case (mon_sel)
            MON_BO_0P2: analog_ctl.burnout_current = 2'h1;
            MON_BO_1:   analog_ctl.burnout_current = 2'h2;
            MON_BO_10:  analog_ctl.burnout_current = 2'h3;
            default:    analog_ctl.burnout_current = 2'h0;
        endcase
        analog_ctl.burnout_route         = analog_ctl.burnout_current != 2'h0;
        analog_ctl.rail_monitor_enable   = excite[EX_RAIL] & (amp_bypass | 1'b1);
        analog_ctl.ref_monitor_enable    = refctl[1:0];
        analog_ctl.ref_pull_together     = refctl[RC_PULL];
        analog_ctl.low_side_switch_close = excite[EX_SWITCH];
    end

    assign status_append_enable = sysctl[SC_APPEND];
    assign prefix_valid         = pvalid;
    assign prefix_byte          = prefix;

endmodule : fault_ctl_bank

// File: hw/fault_ctl_pkg.sv
// Package: register map, field layouts and carrier structs for the fault and control bank
package fault_ctl_pkg;

    // Register byte addresses (one aligned word each)
    localparam logic [7:0] ADDR_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_SYSCTL    = 8'h04;
    localparam logic [7:0] ADDR_BIAS      = 8'h08;
    localparam logic [7:0] ADDR_EXCITE    = 8'h0c;
    localparam logic [7:0] ADDR_REFCTL    = 8'h10;
    localparam logic [7:0] ADDR_GPIO_CFG  = 8'h14;
    localparam logic [7:0] ADDR_GPIO_DATA = 8'h18;
    localparam logic [7:0] ADDR_EFFECT    = 8'h1c;

    // Status byte fields
    localparam int ST_POR     = 7;
    localparam int ST_RDY_N   = 6;
    localparam int ST_P_HIGH  = 5;
    localparam int ST_P_LOW   = 4;
    localparam int ST_N_HIGH  = 3;
    localparam int ST_N_LOW   = 2;
    localparam int ST_REF_LOW = 1;
    localparam int ST_REF_3RD = 0;

    // System control fields: monitor select [2:0], status append [3]
    localparam int SC_APPEND = 3;

    // System monitor select codes
    localparam logic [2:0] MON_NONE    = 3'h0;
    localparam logic [2:0] MON_MID     = 3'h1;
    localparam logic [2:0] MON_TEMP    = 3'h2;
    localparam logic [2:0] MON_AVDD    = 3'h3;
    localparam logic [2:0] MON_IOVDD   = 3'h4;
    localparam logic [2:0] MON_BO_0P2  = 3'h5;
    localparam logic [2:0] MON_BO_1    = 3'h6;
    localparam logic [2:0] MON_BO_10   = 3'h7;

    // Bias register: level [7], enables [6:0] for inputs 0..5 and common
    localparam int BIAS_LEVEL = 7;
    localparam int BIAS_PINS  = 7;

    // Excitation register: switch close [7], rail monitor enable [6]
    localparam int EX_SWITCH = 7;
    localparam int EX_RAIL   = 6;

    // Reference control: enable [1:0], pull-together resistor [2]
    localparam int RC_PULL = 2;

    // Effect register bits: power-down command [0]
    localparam int EF_POWER_DOWN = 0;

    localparam logic [7:0] STATUS_RESET = 8'hc0;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    localparam int         GPIO_PINS    = 4;

    // Analog side controls driven out of the block
    typedef struct packed {
        logic       bias_level_twelfth;
        logic [6:0] bias_pin_enable;
        logic       inputs_disconnect;
        logic       gain_force_unity;
        logic [1:0] burnout_current;
        logic       burnout_route;
        logic       rail_monitor_enable;
        logic [1:0] ref_monitor_enable;
        logic       ref_pull_together;
        logic       low_side_switch_close;
    } analog_ctl_s;

    // Comparator levels seen during a conversion
    typedef struct packed {
        logic pos_high;
        logic pos_low;
        logic neg_high;
        logic neg_low;
        logic ref_low;
        logic ref_third;
    } monitor_raw_s;

endpackage : fault_ctl_pkg

// File: hw/fault_latch.sv
// Conversion-window fault latch with end-of-conversion update
module fault_latch
    import fault_ctl_pkg::*;
#(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Conversion framing
    input  wire logic             conv_start,
    input  wire logic             conv_end,
    // Fault levels and enables
    input  wire logic [WIDTH-1:0] fault_in,
    input  wire logic [WIDTH-1:0] fault_enable,
    // Published flags
    output logic      [WIDTH-1:0] flags
);

    initial begin
        if (WIDTH < 1) $error("fault_latch WIDTH must be positive");
    end

    logic [WIDTH-1:0] seen;
    logic [WIDTH-1:0] next_seen;
    logic [WIDTH-1:0] next_flags;

    // Accumulate during conversion, publish and restart at its end
    always_comb begin
        next_seen  = seen | (fault_in & fault_enable);
        next_flags = flags;
        if (conv_end) begin
            next_flags = next_seen;
            next_seen  = '0;
        end else if (conv_start) begin
            next_seen = fault_in & fault_enable;
        end
    end

    // Register latch state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen  <= '0;
            flags <= '0;
        end else begin
            seen  <= next_seen;
            flags <= next_flags;
        end
    end

endmodule : fault_latch

// File: tb/adc_fault_status_gpio_control_tb_top.sv
// Testbench: status, monitor, GPIO and switch scenarios for the control bank
module adc_fault_status_gpio_control_tb_top
    import fault_ctl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // Bus, engine and pin signals
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    logic [7:0]   s_axi_awaddr, s_axi_araddr, prefix_byte, st, b, ex, g;
    logic [31:0]  s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0]   s_axi_wstrb, gpio_out, gpio_oe, pin_function_select, c;
    logic [3:0]   gpio_in = 4'h0;
    logic [2:0]   rc;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rd_r;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic         startup_done = 1'b0, conv_start = 1'b0, power_down_command = 1'b0;
    logic         data_ready_n = 1'b1, data_read_start = 1'b0, amp_bypass = 1'b0;
    logic         status_append_enable, prefix_valid;
    monitor_raw_s monitor_raw = '0;
    monitor_raw_s raw;
    analog_ctl_s  analog_ctl;
    int           num_errors = 0;
    int           num_checks = 0;

    // Clock of 8 ns
    initial forever #4 aclk = ~aclk;

    // Design and host model
    fault_ctl_bank dut (.*);
    axi_host_model host (.*);

    // Checks, bus wrappers, verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        host.wr(a, d, rd_r);
        check(32'(rd_r), 32'(er));
    endtask : wchk
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        host.rd(a, rd_d, rd_r);
        check(rd_d, e);
        check(32'(rd_r), 32'(er));
    endtask : rchk
    task automatic pulse_read();
        data_read_start <= 1'b1;
        @(posedge aclk);
        data_read_start <= 1'b0;
        @(posedge aclk);
    endtask : pulse_read
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // Expected analog controls
    function automatic analog_ctl_s exp_ctl(logic [2:0] m, logic [7:0] b, ex, logic [2:0] rc);
        analog_ctl_s e;
        e.bias_level_twelfth    = b[BIAS_LEVEL];
        e.bias_pin_enable       = b[6:0];
        e.inputs_disconnect     = (m == MON_AVDD) || (m == MON_IOVDD);
        e.gain_force_unity      = e.inputs_disconnect;
        e.burnout_current       = (m >= MON_BO_0P2) ? 2'(m - 3'h4) : 2'h0;
        e.burnout_route         = (m >= MON_BO_0P2);
        e.rail_monitor_enable   = ex[EX_RAIL];
        e.ref_monitor_enable    = rc[1:0];
        e.ref_pull_together     = rc[RC_PULL];
        e.low_side_switch_close = ex[EX_SWITCH];
        return e;
    endfunction : exp_ctl

    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        $display("wrong value at %0t: run did not finish", $time);
        finish_test();
    end

    // Main sequence
    initial begin
        void'($urandom(72));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ADDR_STATUS, 32'(STATUS_RESET));
        startup_done <= 1'b1;
        rchk(ADDR_STATUS, 32'h80);
        rchk(ADDR_STATUS, 32'h80);
        wchk(ADDR_STATUS, 8'h00);
        rchk(ADDR_STATUS, 32'h00);
        rchk(8'h20, 32'h0, RESP_SLVERR);
        wchk(8'h24, 8'h5a, RESP_SLVERR);
        $display("test status finished");
        // Every monitor code
        for (int m = 0; m < 8; m++) begin
            b  = 8'($urandom);
            ex = 8'($urandom) & 8'hc0;
            rc = 3'($urandom);
            g  = {4'h0, 1'($urandom), 3'(m)};
            wchk(ADDR_SYSCTL, g);
            wchk(ADDR_BIAS, b);
            wchk(ADDR_EXCITE, ex);
            wchk(ADDR_REFCTL, {5'h0, rc});
            check(32'(analog_ctl), 32'(exp_ctl(3'(m), b, ex, rc)));
            check(32'(status_append_enable), 32'(g[SC_APPEND]));
            rchk(ADDR_BIAS, 32'(b));
        end
        $display("test monitor finished");
        wchk(ADDR_EXCITE, 8'h80);
        check(32'(analog_ctl.low_side_switch_close), 32'h1);
        wchk(ADDR_EFFECT, 8'h01);
        check(32'(analog_ctl.low_side_switch_close), 32'h0);
        wchk(ADDR_EXCITE, 8'h80);
        power_down_command <= 1'b1;
        @(posedge aclk);
        power_down_command <= 1'b0;
        @(posedge aclk);
        check(32'(analog_ctl.low_side_switch_close), 32'h0);
        rchk(ADDR_EXCITE, 32'h0);
        $display("test switch finished");
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 4'hf : 4'($urandom);
            g = 8'($urandom);
            gpio_in <= 4'($urandom);
            wchk(ADDR_GPIO_CFG, {4'h0, c});
            wchk(ADDR_GPIO_DATA, g);
            check(32'({gpio_oe, pin_function_select}), 32'({c & g[7:4], c}));
            check(32'(gpio_out & g[7:4]), 32'(g[3:0] & g[7:4]));
            rchk(ADDR_GPIO_DATA, 32'({g[7:4], (g[3:0] & g[7:4]) | (gpio_in & ~g[7:4])}));
        end
        $display("test gpio finished");
        st = 8'h00;
        wchk(ADDR_SYSCTL, 8'h08);
        for (int i = 0; i < 5; i++) begin
            ex  = (i == 4) ? 8'h00 : 8'h40;
            rc  = 3'(i);
            raw = (i == 1) ? 6'h00 : 6'($urandom);
            wchk(ADDR_EXCITE, ex);
            wchk(ADDR_REFCTL, {5'h0, rc});
            conv_start <= 1'b1;
            @(posedge aclk);
            conv_start  <= 1'b0;
            monitor_raw <= raw;
            amp_bypass  <= 1'($urandom);
            repeat (3) @(posedge aclk);
            monitor_raw <= '0;
            repeat (2) @(posedge aclk);
            rchk(ADDR_STATUS, 32'(st));
            data_ready_n <= 1'b0;
            repeat (2) @(posedge aclk);
            data_ready_n <= 1'b1;
            st = {2'b00, raw & {{4{ex[EX_RAIL]}}, rc[1:0]}};
            rchk(ADDR_STATUS, 32'(st));
            pulse_read();
            check(32'({prefix_valid, prefix_byte}), 32'({1'b1, st}));
        end
        wchk(ADDR_SYSCTL, 8'h00);
        pulse_read();
        check(32'(prefix_valid), 32'h0);
        $display("test flags finished");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check(32'(analog_ctl), 32'h0);
        rchk(ADDR_STATUS, 32'h80);
        $display("test reset finished");
        finish_test();
    end
endmodule : adc_fault_status_gpio_control_tb_top

// File: tb/axi_host_model.sv
// Host model: AXI4-Lite master issuing one register access at a time
module axi_host_model (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic      [7:0]  s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic      [31:0] s_axi_wdata,
    output logic      [3:0]  s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels
    output logic      [7:0]  s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
    end

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        bit aw_ok;
        bit w_ok;
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        s_axi_awaddr <= a;
        s_axi_wdata  <= {24'h0, d};
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~{24'h0, d};
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        s_axi_araddr <= a;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        d    = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : axi_host_model

// File: tb/fault_ctl_bank_properties.sv
// Checker: port-level properties of the fault and control bank
module fault_ctl_bank_properties
    import fault_ctl_pkg::*;
#(
    parameter int PINS = GPIO_PINS
) (
    // Clock and reset
    input wire logic            aclk,
    input wire logic            aresetn,
    // Bus handshakes
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    // Block controls
    input wire logic            power_down_command,
    input wire logic            data_read_start,
    input wire logic [PINS-1:0] gpio_oe,
    input wire logic [PINS-1:0] pin_function_select,
    input wire analog_ctl_s     analog_ctl,
    input wire logic            status_append_enable,
    input wire logic            prefix_valid
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Transfer steps
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence prefix_asked;
        data_read_start && status_append_enable;
    endsequence

    write_resp_a: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_resp_a: assert property (read_taken |=> s_axi_rvalid)
        else $error("read response late");
    switch_open_a: assert property (power_down_command |=> !analog_ctl.low_side_switch_close)
        else $error("switch not opened");
    reset_default_a: assert property ($rose(aresetn) |-> analog_ctl == '0 && !status_append_enable)
        else $error("controls not at default");
    pin_drive_a: assert property ((gpio_oe & ~pin_function_select) == '0)
        else $error("analog pin driven");
    monitor_mode_a: assert property (analog_ctl.inputs_disconnect |->
        analog_ctl.gain_force_unity && analog_ctl.burnout_current == 2'h0)
        else $error("supply monitor mode wrong");
    burnout_route_a: assert property (analog_ctl.burnout_route == (analog_ctl.burnout_current != 2'h0))
        else $error("burnout routing wrong");
    prefix_load_a: assert property (prefix_asked |=> prefix_valid)
        else $error("prefix missing");
    prefix_cause_a: assert property (prefix_valid |-> $past(data_read_start && status_append_enable))
        else $error("prefix without cause");
endmodule : fault_ctl_bank_properties

bind fault_ctl_bank fault_ctl_bank_properties #(.PINS(PINS)) props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .power_down_command,
    .data_read_start, .gpio_oe, .pin_function_select, .analog_ctl, .status_append_enable,
    .prefix_valid
);
